/* File: hdl/sram_host_pkg.sv */
package sram_host_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_RC_NS = 70;
   localparam int T_AA_NS = 70;
   localparam int T_DOE_NS = 35;
   localparam int T_WC_NS = 70;
   localparam int T_SCE_NS = 60;
   localparam int T_PWE_NS = 50;
   localparam int T_SD_NS = 30;
   localparam int T_HZOE_NS = 25;
   localparam int CNT_W = 4;
   // Least times round up, never below one cycle
   function automatic int cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam logic [CNT_W-1:0] RD_CYC =
      CNT_W'(cyc((T_AA_NS > T_RC_NS) ? T_AA_NS : T_RC_NS));
   localparam logic [CNT_W-1:0] WR_CYC =
      CNT_W'(cyc((T_SCE_NS > T_PWE_NS) ? T_SCE_NS : T_PWE_NS));
   localparam logic [CNT_W-1:0] WC_CYC = CNT_W'(cyc(T_WC_NS));
   localparam logic [CNT_W-1:0] SD_CYC = CNT_W'(cyc(T_SD_NS));
   localparam logic [CNT_W-1:0] HZ_CYC = CNT_W'(cyc(T_HZOE_NS));
   localparam logic [CNT_W-1:0] DOE_CYC = CNT_W'(cyc(T_DOE_NS));
endpackage

/* File: hdl/sram_host.sv */
`timescale 1ns/1ns
module sram_host
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr_in,
   input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_out,
   output logic [sram_host_pkg::ADDR_W-1:0] word_address_out,
   output logic chip_sel_n_out,
   output logic write_n_out,
   output logic out_en_n_out,
   input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_in,
   output logic [sram_host_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe_out
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {IDLE, RD, WR_TURN, WR, RECOVER} state_type;

   state_type state_q, state_d;
   logic [sram_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [sram_host_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [sram_host_pkg::DATA_W-1:0] wdata_q, wdata_d;
   logic [sram_host_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic cs_n_q, cs_n_d;
   logic we_n_q, we_n_d;
   logic oe_n_q, oe_n_d;
   logic drive_q, drive_d;
   logic rsp_q, rsp_d;
   logic last_cycle;

   // Every phase but IDLE ends on the cycle its counter reaches one
   assign last_cycle = (cnt_q == 4'h1);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: the phase and the cycles left in it
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         IDLE:
         begin
            if (req_valid_in)
            begin
               if (req_write_in)
               begin
                  // Wait for the bus to float before driving it
                  state_d = WR_TURN;
                  cnt_d = sram_host_pkg::HZ_CYC;
               end
               else
               begin
                  state_d = RD;
                  cnt_d = (sram_host_pkg::RD_CYC > sram_host_pkg::DOE_CYC)
                     ? sram_host_pkg::RD_CYC : sram_host_pkg::DOE_CYC;
               end
            end
         end
         RD:
         begin
            // Sample once every access time has elapsed
            if (last_cycle)
            begin
               state_d = RECOVER;
               cnt_d = sram_host_pkg::HZ_CYC;
            end
            else
            begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         WR_TURN:
         begin
            if (last_cycle)
            begin
               state_d = WR;
               // Strobe width covers select, strobe, data set-up and cycle
               cnt_d = (sram_host_pkg::WR_CYC > sram_host_pkg::WC_CYC)
                  ? sram_host_pkg::WR_CYC : sram_host_pkg::WC_CYC;
               if (sram_host_pkg::SD_CYC > cnt_d)
                  cnt_d = sram_host_pkg::SD_CYC;
            end
            else
            begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         WR:
         begin
            if (last_cycle)
            begin
               // One cycle of data hold follows the end of the write
               state_d = RECOVER;
               cnt_d = 4'h1;
            end
            else
            begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         RECOVER:
         begin
            if (last_cycle)
            begin
               state_d = IDLE;
            end
            else
            begin
               cnt_d = cnt_q - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= IDLE;
         cnt_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins: address, write data and the three strobes
   always_comb
   begin
      addr_d = addr_q;
      wdata_d = wdata_q;
      cs_n_d = cs_n_q;
      we_n_d = we_n_q;
      oe_n_d = oe_n_q;
      drive_d = drive_q;
      unique case (state_q)
         IDLE:
         begin
            // Deselected between accesses, so the memory idles in standby
            cs_n_d = 1'b1;
            we_n_d = 1'b1;
            oe_n_d = 1'b1;
            drive_d = 1'b0;
            if (req_valid_in)
            begin
               // Address set together with select, and with the output enable on a read; the write strobe comes later
               addr_d = req_addr_in;
               wdata_d = req_wdata_in;
               cs_n_d = 1'b0;
               if (!req_write_in)
               begin
                  oe_n_d = 1'b0;
               end
            end
         end
         RD:
         begin
            if (last_cycle)
            begin
               oe_n_d = 1'b1;
               cs_n_d = 1'b1;
            end
         end
         WR_TURN:
         begin
            if (last_cycle)
            begin
               drive_d = 1'b1;
               we_n_d = 1'b0;
            end
         end
         WR:
         begin
            if (last_cycle)
            begin
               // Strobe and select rise together; data and address held
               // through this edge, so zero hold is met
               we_n_d = 1'b1;
               cs_n_d = 1'b1;
            end
         end
         RECOVER:
         begin
            // Release data one cycle after the write ends
            drive_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         addr_q <= 15'h0000;
         wdata_q <= 8'h00;
         cs_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         drive_q <= 1'b0;
      end
      else
      begin
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         cs_n_q <= cs_n_d;
         we_n_q <= we_n_d;
         oe_n_q <= oe_n_d;
         drive_q <= drive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response: read data is caught once and held until the next read
   always_comb
   begin
      rdata_d = rdata_q;
      rsp_d = 1'b0;
      if ((state_q == RD) && last_cycle)
      begin
         rdata_d = data_lines_in;
         rsp_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rdata_q <= 8'h00;
         rsp_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rsp_q <= rsp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign req_ready_out = (state_q == IDLE);
   assign rsp_valid_out = rsp_q;
   assign rsp_rdata_out = rdata_q;
   assign word_address_out = addr_q;
   assign chip_sel_n_out = cs_n_q;
   assign write_n_out = we_n_q;
   assign out_en_n_out = oe_n_q;
   assign data_lines_out = wdata_q;
   assign data_lines_oe_out = drive_q;
endmodule

/* File: dv/sram_host_asserts.sv */
`timescale 1ns/1ns
module sram_host_asserts
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr_in,
   input wire logic [sram_host_pkg::ADDR_W-1:0] word_address_out,
   input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata_in,
   input wire logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_out,
   input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_in,
   input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_out,
   input wire logic req_ready_out,
   input wire logic rsp_valid_out,
   input wire logic chip_sel_n_out,
   input wire logic write_n_out,
   input wire logic out_en_n_out,
   input wire logic data_lines_oe_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence take(w);
      req_valid_in && req_ready_out && req_write_in == w;
   endsequence
   sequence wr_steps;
      (!chip_sel_n_out && write_n_out) ##1 (!write_n_out && data_lines_oe_out)
      ##1 (write_n_out && chip_sel_n_out);
   endsequence
   a_write_steps: assert property (take(1'b1) |=> wr_steps)
      else $error("write strobe order wrong");
   a_read_answer: assert property (take(1'b0) |=>
      (!chip_sel_n_out && !out_en_n_out && write_n_out) ##[1:2] rsp_valid_out)
      else $error("read cycle wrong");
   a_read_sample: assert property (rsp_valid_out |->
      rsp_rdata_out == $past(data_lines_in)) else $error("read data lost");
   a_no_contend: assert property (
      !out_en_n_out |-> !data_lines_oe_out)
      else $error("host drives during memory output");
   a_write_overlap: assert property (!write_n_out |-> !chip_sel_n_out)
      else $error("strobe without select");
   a_sel_lead: assert property (
      $fell(write_n_out) |-> !$past(chip_sel_n_out))
      else $error("select not ahead of strobe");
   a_addr_steady: assert property (
      !chip_sel_n_out && !$past(chip_sel_n_out) |-> $stable(word_address_out))
      else $error("address moved");
   a_data_hold: assert property ($rose(write_n_out) |->
      data_lines_oe_out && $stable(data_lines_out)) else $error("data not held");
   a_idle_deselect: assert property (req_ready_out |-> chip_sel_n_out)
      else $error("selected while idle");
endmodule
bind sram_host sram_host_asserts sram_host_asserts_i(.clk_sys_in(clk_sys_in),
   .rst_in(rst_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
   .req_addr_in(req_addr_in), .word_address_out(word_address_out),
   .req_wdata_in(req_wdata_in), .rsp_rdata_out(rsp_rdata_out),
   .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
   .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
   .chip_sel_n_out(chip_sel_n_out), .write_n_out(write_n_out),
   .out_en_n_out(out_en_n_out), .data_lines_oe_out(data_lines_oe_out));

/* File: dv/sram_device.sv */
`timescale 1ns/1ns
module sram_device
(
   input wire logic [14:0] word_address_in,
   input wire logic chip_sel_n_in,
   input wire logic write_n_in,
   input wire logic out_en_n_in,
   input wire logic slow_in,
   input wire logic [7:0] data_lines_in,
   output logic [7:0] data_lines_out,
   output logic drive_out
);
   logic [7:0] mem [0:32767];
   logic [7:0] rd_d;
   wire logic wr_n = chip_sel_n_in | write_n_in;
   always @(posedge wr_n) mem[word_address_in] = data_lines_in;
   assign drive_out = !chip_sel_n_in && write_n_in
      && !out_en_n_in;
   // Undriven lines show the complement of the addressed word, after the same delay as driven data
   always @*
      rd_d = drive_out ? mem[word_address_in] : ~mem[word_address_in];
   // Old data outlasts an address change by the whole delay, 10 ns fast or 65 ns slow
   always @(rd_d)
      data_lines_out <= #(slow_in ? 65 : 10) rd_d;
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
   logic clk_sys_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0;
   logic slow = 0, drive, req_ready_out, rsp_valid_out, chip_sel_n_out;
   logic write_n_out, out_en_n_out, data_lines_oe_out;
   logic [14:0] req_addr_in = 15'h0000, word_address_out;
   logic [7:0] req_wdata_in = 8'h00, rsp_rdata_out, data_lines_out, mem_q, dq;
   int n_mismatch = 0, n_tests = 0, cycles = 0;
   assign dq = data_lines_oe_out ? data_lines_out : mem_q;
   sram_host sram_host_i(.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .req_valid_in(req_valid_in), .req_write_in(req_write_in),
      .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
      .rsp_rdata_out(rsp_rdata_out), .word_address_out(word_address_out),
      .chip_sel_n_out(chip_sel_n_out), .write_n_out(write_n_out),
      .out_en_n_out(out_en_n_out), .data_lines_in(dq),
      .data_lines_out(data_lines_out), .data_lines_oe_out(data_lines_oe_out));
   sram_device sram_device_i(.word_address_in(word_address_out),
      .chip_sel_n_in(chip_sel_n_out), .write_n_in(write_n_out),
      .out_en_n_in(out_en_n_out), .slow_in(slow), .data_lines_in(dq),
      .data_lines_out(mem_q), .drive_out(drive));
   initial forever #50 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) if (++cycles == 3000) tally_and_finish(1);
   // Both sides on the data lines at once would corrupt the wire
   always @(negedge clk_sys_in)
      if (drive === 1'b1 && data_lines_oe_out === 1'b1)
         check("contention", 8'h01, 8'h00);
   task tally_and_finish(input bit hung);
      n_mismatch += hung;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Ready is sampled at the falling edge, clear of the launching edge
   task automatic req(input logic w, input logic [14:0] a,
      input logic [7:0] d);
      @(posedge clk_sys_in);
      #2 req_valid_in = 1'b1;
      req_write_in = w;
      req_addr_in = a;
      req_wdata_in = d;
      forever
      begin
         @(negedge clk_sys_in);
         if (req_ready_out === 1'b1) break;
      end
      @(posedge clk_sys_in);
      #2 req_valid_in = 0;
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] exp);
      req(0, a, 8'h00);
      repeat (8)
      begin
         @(negedge clk_sys_in);
         if (rsp_valid_out === 1'b1) break;
      end
      check("response", {7'h00, rsp_valid_out}, 8'h01);
      check("read data", rsp_rdata_out, exp);
   endtask
   task t_idle;
      check("select", {7'h00, chip_sel_n_out}, 8'h01);
      check("strobe", {7'h00, write_n_out}, 8'h01);
      check("host drive", {7'h00, data_lines_oe_out}, 8'h00);
   endtask
   task t_edges;
      req(1, 15'h0000, 8'hA5);
      req(1, 15'h7FFF, 8'h5A);
      rd(15'h0000, 8'hA5);
      rd(15'h7FFF, 8'h5A);
   endtask
   task t_slow;
      slow = 1;
      req(1, 15'h1234, 8'h3C);
      rd(15'h1234, 8'h3C);
      req(1, 15'h1234, 8'hC3);
      rd(15'h1234, 8'hC3);
   endtask
   task t_reset_mid;
      req(1, 15'h0001, 8'h77);
      rst_in = 1;
      #5 t_idle();
      repeat (2) @(posedge clk_sys_in);
      #2 rst_in = 0;
      rd(15'h1234, 8'hC3);
   endtask
   initial
   begin
      repeat (16) @(posedge clk_sys_in);
      #2 rst_in = 0;
      t_idle();
      t_edges();
      t_slow();
      t_idle();
      t_reset_mid();
      tally_and_finish(0);
   end
endmodule
